// >>> sfpc_pkg.sv
package sfpc_pkg;

    // ----------------------------------------------------------------
    // Timing, all derived from the 20 MHz core clock
    // ----------------------------------------------------------------
    localparam int CLK_NS = 50;
    localparam int SYNC_STAGES = 2;
    // Strobe low time, well above the part's glitch filter
    localparam int WE_LOW_NS = 100;
    localparam int WE_LOW_CYC = (WE_LOW_NS + CLK_NS - 1) / CLK_NS;
    // Read settle time, plus the input synchroniser delay
    localparam int RD_ACC_NS = 150;
    localparam int RD_CYC = (RD_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES;
    // Inter-byte load window; longest time, rounded down
    localparam int LOAD_WINDOW_US = 150;
    localparam int WINDOW_CYC = (LOAD_WINDOW_US * 1000) / CLK_NS;
    // Quiet time after the last load, strictly longer than the window
    localparam int CLOSE_CYC = WINDOW_CYC + 1;
    localparam int PWRUP_MS = 5;
    localparam int PWRUP_CYC = (PWRUP_MS * 1000000) / CLK_NS;
    localparam int PROG_CYCLE_MS = 10;
    localparam int PROG_CYCLE_CYC = (PROG_CYCLE_MS * 1000000) / CLK_NS;
    // Typical figure only, so the poll timeout allows twice it
    localparam int POLL_MARGIN = 2;
    localparam int PROG_TIMEOUT_CYC = PROG_CYCLE_CYC * POLL_MARGIN;

    // ----------------------------------------------------------------
    // Geometry and widths
    // ----------------------------------------------------------------
    localparam int SECTOR_BYTES = 128;
    localparam int CMD_LEN = 3;
    localparam int TMR_W = 20;
    localparam int WCNT_W = 3;
    localparam logic [6:0] LAST_OFFSET = 7'h7F;
    localparam logic [15:0] ID_BASE = 16'h0000;

    // ----------------------------------------------------------------
    // Command sequences; set to the attached part's codes
    // ----------------------------------------------------------------
    localparam logic [2:0][16:0] CMD_ADDR = {17'h01555, 17'h00AAA, 17'h01555};
    localparam logic [2:0][7:0] CMD_UNLOCK = {8'hA0, 8'h55, 8'hAA};
    localparam logic [2:0][7:0] CMD_ID_IN = {8'h90, 8'h55, 8'hAA};
    localparam logic [2:0][7:0] CMD_ID_OUT = {8'hF0, 8'h55, 8'hAA};

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        OP_READ = 2'h0,
        OP_LOAD = 2'h1,
        OP_PROG = 2'h2,
        OP_ID = 2'h3
    } sfpc_op_e;

    typedef enum logic [1:0] {
        PH_PRE = 2'h0,
        PH_BODY = 2'h1,
        PH_POLL = 2'h2,
        PH_POST = 2'h3
    } sfpc_phase_e;

    typedef enum logic [8:0] {
        ST_PWRUP = 9'h001,
        ST_IDLE = 9'h002,
        ST_SEQ = 9'h004,
        ST_WSET = 9'h008,
        ST_WLOW = 9'h010,
        ST_WHIGH = 9'h020,
        ST_READ = 9'h040,
        ST_WAIT = 9'h080,
        ST_SPARE = 9'h100
    } sfpc_state_e;

    typedef struct packed {
        logic valid;
        sfpc_op_e op;
        logic [16:0] addr;
        logic [7:0] data;
    } sfpc_req_s;

    typedef struct packed {
        logic valid;
        logic err;
        logic [7:0] data;
    } sfpc_rsp_s;

    typedef struct packed {
        logic [16:0] addr;
        logic [7:0] dq_out;
        logic dq_oe;
        logic ce_n;
        logic oe_n;
        logic we_n;
    } sfpc_pins_s;

    typedef struct packed {
        sfpc_state_e fsm;
        sfpc_op_e job;
        sfpc_phase_e phase;
        logic [1:0] pre;
        logic [7:0] bidx;
        logic [9:0] sector;
        logic [16:0] raddr;
        logic [16:0] addr;
        logic [7:0] dout;
        logic dq_oe;
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic [WCNT_W-1:0] wcnt;
        logic [7:0] rdat;
        logic [7:0] dq_s1;
        logic [7:0] dq_s2;
        logic ready;
        logic rsp_v;
        logic rsp_err;
    } sfpc_state_s;

    typedef struct packed {
        logic [TMR_W-1:0] cnt;
    } sfpc_tmr_s;

endpackage : sfpc_pkg

// >>> sfpc_timer.sv
`timescale 1ns/100ps
module sfpc_timer
    import sfpc_pkg::*;
#(
    parameter logic [TMR_W-1:0] INIT = '0
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic load,
    input wire logic [TMR_W-1:0] load_val,
    output logic done
);

    sfpc_tmr_s st;
    sfpc_tmr_s next_st;

    // Down counter; a load wins over the count
    always_comb begin
        next_st = st;
        if (load) begin
            next_st.cnt = load_val;
        end else if (st.cnt != '0) begin
            next_st.cnt = st.cnt - 1'b1;
        end
    end

    // Starts already loaded so power-up waits without a trigger
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st <= '{cnt: INIT};
        end else begin
            st <= next_st;
        end
    end

    assign done = (st.cnt == '0);

endmodule : sfpc_timer

// >>> sfpc_host.sv
`timescale 1ns/100ps
module sfpc_host
    import sfpc_pkg::*;
#(
    parameter int unsigned PWRUP_WAIT = PWRUP_CYC,
    parameter int unsigned POLL_LIMIT = PROG_TIMEOUT_CYC
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire sfpc_req_s req,
    output logic req_ready,
    output sfpc_rsp_s rsp,
    input wire logic lock_on,
    output sfpc_pins_s pins,
    input wire logic [7:0] pin_dq_in
);

    // ----------------------------------------------------------------
    // State, sector buffer and timer
    // ----------------------------------------------------------------
    // Enum fields named so the default value never lands on an enum
    localparam sfpc_state_s ST_RST = '{fsm: ST_PWRUP, job: OP_READ, phase: PH_PRE,
                                       ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, default: '0};

    sfpc_state_s st;
    sfpc_state_s next_st;
    logic [7:0] sec_buf [SECTOR_BYTES];
    logic tmr_load;
    logic [TMR_W-1:0] tmr_val;
    logic tmr_done;

    sfpc_timer #(
        .INIT(TMR_W'(PWRUP_WAIT))
    ) u_timer (
        .core_clk(core_clk),
        .rstn(rstn),
        .load(tmr_load),
        .load_val(tmr_val),
        .done(tmr_done)
    );

    // Staging buffer lets a whole sector burst out inside the window
    always_ff @(posedge core_clk) begin
        if (st.fsm == ST_IDLE && req.valid && req.op == OP_LOAD) begin
            sec_buf[req.addr[6:0]] <= req.data;
        end
    end

    // ----------------------------------------------------------------
    // Bus cycle helpers
    // ----------------------------------------------------------------
    // Drive address and data first; strobes follow one cycle later
    function automatic sfpc_state_s start_wr(input sfpc_state_s s, input logic [16:0] a, input logic [7:0] d);
        sfpc_state_s r;
        r = s;
        r.addr = a;
        r.dout = d;
        r.dq_oe = 1'b1;
        r.fsm = ST_WSET;
        return r;
    endfunction : start_wr

    // Both enables low, write enable held high for the whole read
    function automatic sfpc_state_s start_rd(input sfpc_state_s s, input logic [16:0] a);
        sfpc_state_s r;
        r = s;
        r.addr = a;
        r.dq_oe = 1'b0;
        r.ce_n = 1'b0;
        r.oe_n = 1'b0;
        r.wcnt = WCNT_W'(RD_CYC - 1);
        r.fsm = ST_READ;
        return r;
    endfunction : start_rd

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always_comb begin
        next_st = st;
        tmr_load = 1'b0;
        tmr_val = '0;
        next_st.rsp_v = 1'b0;
        case (st.fsm)
            ST_PWRUP: begin
                if (tmr_done) begin
                    next_st.fsm = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (req.valid) begin
                    next_st.job = req.op;
                    next_st.phase = PH_PRE;
                    next_st.pre = '0;
                    next_st.bidx = '0;
                    next_st.sector = req.addr[16:7];
                    next_st.raddr = req.addr;
                    next_st.rsp_err = 1'b0;
                    if (req.op == OP_LOAD) begin
                        next_st.rsp_v = 1'b1;
                        next_st.rdat = req.data;
                    end else begin
                        next_st.fsm = ST_SEQ;
                    end
                end
            end
            ST_SEQ: begin
                case (st.job)
                    OP_PROG: begin
                        // lock prefix before any data load
                        if (st.phase == PH_PRE) begin
                            if (lock_on && st.pre < 2'(CMD_LEN)) begin
                                next_st = start_wr(st, CMD_ADDR[st.pre], CMD_UNLOCK[st.pre]);
                                next_st.pre = st.pre + 1'b1;
                            end else begin
                                next_st.phase = PH_BODY;
                            end
                        end else if (st.phase == PH_BODY) begin
                            if (st.bidx < 8'(SECTOR_BYTES)) begin
                                next_st = start_wr(st, {st.sector, st.bidx[6:0]}, sec_buf[st.bidx[6:0]]);
                                next_st.bidx = st.bidx + 1'b1;
                            end else begin
                                tmr_load = 1'b1;
                                tmr_val = TMR_W'(CLOSE_CYC);
                                next_st.fsm = ST_WAIT;
                            end
                        // true bit seven ends the wait
                        end else begin
                            if (st.rdat[7] == sec_buf[LAST_OFFSET][7]) begin
                                next_st.rsp_v = 1'b1;
                                next_st.fsm = ST_IDLE;
                            end else if (tmr_done) begin
                                next_st.rsp_v = 1'b1;
                                next_st.rsp_err = 1'b1;
                                next_st.fsm = ST_IDLE;
                            end else begin
                                next_st = start_rd(st, {st.sector, LAST_OFFSET});
                            end
                        end
                    end
                    OP_ID: begin
                        if (st.phase == PH_PRE && st.pre < 2'(CMD_LEN)) begin
                            next_st = start_wr(st, CMD_ADDR[st.pre], CMD_ID_IN[st.pre]);
                            next_st.pre = st.pre + 1'b1;
                        end else if (st.phase == PH_PRE) begin
                            next_st = start_rd(st, {ID_BASE, st.raddr[0]});
                            next_st.phase = PH_POST;
                            next_st.pre = '0;
                        end else if (st.pre < 2'(CMD_LEN)) begin
                            next_st = start_wr(st, CMD_ADDR[st.pre], CMD_ID_OUT[st.pre]);
                            next_st.pre = st.pre + 1'b1;
                        end else begin
                            next_st.rsp_v = 1'b1;
                            next_st.fsm = ST_IDLE;
                        end
                    end
                    default: begin
                        if (st.phase == PH_PRE) begin
                            next_st = start_rd(st, st.raddr);
                            next_st.phase = PH_POST;
                        end else begin
                            next_st.rsp_v = 1'b1;
                            next_st.fsm = ST_IDLE;
                        end
                    end
                endcase
            end
            ST_WSET: begin
                next_st.ce_n = 1'b0;
                next_st.we_n = 1'b0;
                next_st.wcnt = WCNT_W'(WE_LOW_CYC - 1);
                next_st.fsm = ST_WLOW;
            end
            ST_WLOW: begin
                if (st.wcnt != '0) begin
                    next_st.wcnt = st.wcnt - 1'b1;
                end else begin
                    next_st.we_n = 1'b1;
                    next_st.ce_n = 1'b1;
                    next_st.fsm = ST_WHIGH;
                end
            end
            // Data held one cycle past the rising strobes
            ST_WHIGH: begin
                next_st.dq_oe = 1'b0;
                next_st.fsm = ST_SEQ;
            end
            ST_READ: begin
                if (st.wcnt != '0) begin
                    next_st.wcnt = st.wcnt - 1'b1;
                end else begin
                    next_st.rdat = st.dq_s2;
                    next_st.ce_n = 1'b1;
                    next_st.oe_n = 1'b1;
                    next_st.fsm = ST_SEQ;
                end
            end
            // bus quiet until the load period closes
            ST_WAIT: begin
                if (tmr_done) begin
                    tmr_load = 1'b1;
                    tmr_val = TMR_W'(POLL_LIMIT);
                    next_st = start_rd(st, {st.sector, LAST_OFFSET});
                    next_st.phase = PH_POLL;
                end
            end
            default: begin
                next_st.fsm = ST_IDLE;
            end
        endcase
        // Synchroniser set last; the bus helpers copy stale flops otherwise
        next_st.dq_s1 = pin_dq_in;
        next_st.dq_s2 = st.dq_s1;
        next_st.ready = (next_st.fsm == ST_IDLE);
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st <= ST_RST;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from state flops
    assign req_ready = st.ready;
    assign rsp = '{valid: st.rsp_v, err: st.rsp_err, data: st.rdat};
    assign pins = '{addr: st.addr, dq_out: st.dout, dq_oe: st.dq_oe, ce_n: st.ce_n, oe_n: st.oe_n, we_n: st.we_n};

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    // Cycles since the last strobe rise inside a sector burst
    logic [12:0] gap_cnt;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            gap_cnt <= '0;
        end else if (!st.we_n || st.phase != PH_BODY || st.bidx == '0 || st.fsm == ST_WAIT) begin
            gap_cnt <= '0;
        end else begin
            gap_cnt <= gap_cnt + 1'b1;
        end
    end

    chk_no_contention: assert property (@(posedge core_clk) disable iff (!rstn) st.dq_oe |-> st.oe_n)
        else $error("data driven while output enable low");
    chk_we_with_ce: assert property (@(posedge core_clk) disable iff (!rstn) !st.we_n |-> !st.ce_n && st.oe_n)
        else $error("write strobe without chip enable");
    chk_we_pulse_width: assert property (@(posedge core_clk) disable iff (!rstn) $fell(st.we_n) |-> (!st.we_n)[*2])
        else $error("write strobe too short");
    chk_load_gap: assert property (@(posedge core_clk) disable iff (!rstn) gap_cnt < 13'(WINDOW_CYC))
        else $error("inter-byte load gap too long");
    chk_sector_stable: assert property (@(posedge core_clk) disable iff (!rstn)
        $fell(st.we_n) && st.phase == PH_BODY |-> st.addr[16:7] == st.sector)
        else $error("sector address changed in burst");
    chk_full_sector: assert property (@(posedge core_clk) disable iff (!rstn)
        $rose(st.fsm == ST_WAIT) |-> st.bidx == 8'(SECTOR_BYTES))
        else $error("program started with partial sector");
    chk_quiet_wait: assert property (@(posedge core_clk) disable iff (!rstn)
        st.fsm == ST_WAIT |-> st.ce_n && st.we_n && st.oe_n)
        else $error("bus access before polling");
    chk_prefix_first: assert property (@(posedge core_clk) disable iff (!rstn)
        lock_on && st.job == OP_PROG && st.phase == PH_BODY && $fell(st.we_n) |-> st.pre == 2'(CMD_LEN))
        else $error("locked load without command prefix");
    chk_read_we_high: assert property (@(posedge core_clk) disable iff (!rstn) !st.oe_n |-> st.we_n ##1 st.we_n)
        else $error("write enable low during read");

    cov_prog_ok: cover property (@(posedge core_clk) disable iff (!rstn) st.rsp_v && st.job == OP_PROG && !st.rsp_err);
    cov_prog_err: cover property (@(posedge core_clk) disable iff (!rstn) st.rsp_v && st.rsp_err);
    cov_id_read: cover property (@(posedge core_clk) disable iff (!rstn) st.rsp_v && st.job == OP_ID);

endmodule : sfpc_host

// >>> sfpc_flash_model.sv
`timescale 1ns/100ps
module sfpc_flash_model
    import sfpc_pkg::*;
#(
    parameter int WIN_NS = 150000,
    parameter int PROG_NS = 1000,
    parameter int SLOW_NS = 100000,
    parameter int PWR_NS = 500,
    // Identity bytes: arbitrary values
    parameter logic [7:0] MFG_CODE = 8'h3C,
    parameter logic [7:0] DEV_CODE = 8'h6A
) (
    input wire logic [16:0] addr,
    input wire logic [7:0] dq_bus,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic slow,
    output logic [7:0] dev_dq,
    output logic dev_oe,
    output int viol
);
    // ----------------------------------------------------------------
    // Array and load state
    // ----------------------------------------------------------------
    logic [7:0] mem [int];
    logic [16:0] ld_a [$];
    logic [7:0] ld_d [$];
    logic [16:0] a_lat;
    logic [7:0] last_d;
    logic [2:0][7:0] h;
    logic lock = 1'b0;
    logic pref = 1'b0;
    logic id_mode = 1'b0;
    logic busy = 1'b0;
    logic pend = 1'b0;
    logic tog = 1'b0;
    time t_fall;
    time t_rise;
    wire wr_n = ce_n | we_n;

    initial viol = 0;

    always @(negedge wr_n) begin
        t_fall = $time;
        a_lat = addr;
        if (busy || !oe_n)
            viol++;
    end

    always @(posedge wr_n) begin
        if (oe_n && !busy && $time - t_fall >= 15 && $time >= PWR_NS) begin
            ld_a.push_back(a_lat);
            ld_d.push_back(dq_bus);
            t_rise = $time;
            pend = 1'b1;
            if (ld_a.size() == 3 && !pref && {ld_a[2], ld_a[1], ld_a[0]} == CMD_ADDR) begin
                h = {ld_d[2], ld_d[1], ld_d[0]};
                if (h == CMD_UNLOCK) begin
                    lock = 1'b1;
                    pref = 1'b1;
                end
                if (h == CMD_ID_IN || h == CMD_ID_OUT) begin
                    id_mode = (h == CMD_ID_IN);
                    pend = 1'b0;
                end
                if (pref || !pend) begin
                    ld_a.delete();
                    ld_d.delete();
                end
            end
        end
    end

    // Quiet window closes the load period
    initial forever begin
        #10;
        if (pend && wr_n && $time - t_rise >= WIN_NS) begin
            pend = 1'b0;
            busy = 1'b1;
            last_d = ld_d[$];
            if (!lock || pref) begin
                for (int i = 0; i < 128; i++)
                    mem[{ld_a[0][16:7], 7'(i)}] = 8'hFF;
                foreach (ld_a[i])
                    mem[ld_a[i]] = ld_d[i];
            end
            pref = 1'b0;
            ld_a.delete();
            ld_d.delete();
            #(slow ? SLOW_NS : PROG_NS);
            busy = 1'b0;
        end
    end

    always @(negedge oe_n) begin
        if (busy)
            tog = ~tog;
    end

    // Drive only on a true read
    assign dev_oe = !ce_n && !oe_n && we_n;
    always @(addr, dev_oe, busy, id_mode, tog) begin
        if (!dev_oe)
            dev_dq = ~dev_dq; // Released line must not hold a stale byte
        else if (busy)
            dev_dq = {~last_d[7], tog, last_d[5:0]};
        else if (id_mode)
            dev_dq = addr[0] ? DEV_CODE : MFG_CODE;
        else
            dev_dq = mem.exists(addr) ? mem[addr] : 8'hFF;
    end
endmodule : sfpc_flash_model

// >>> sector_flash_program_ctrl_tb_top.sv
`timescale 1ns/100ps
module sector_flash_program_ctrl_tb_top
    import sfpc_pkg::*;
;
    // ----------------------------------------------------------------
    // Signals and instances
    // ----------------------------------------------------------------
    localparam int PW = 20;
    localparam logic [7:0] MFG = 8'h3C; // Arbitrary value
    localparam logic [7:0] DEV = 8'h6A; // Arbitrary value
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic lock_on = 1'b0;
    logic slow = 1'b0;
    sfpc_req_s req = '0;
    logic req_ready;
    sfpc_rsp_s rsp;
    sfpc_rsp_s r;
    sfpc_pins_s pins;
    wire logic [7:0] dq_bus;
    logic [7:0] dev_dq;
    logic dev_oe;
    int viol;
    int n_fail = 0;
    int cmp_count = 0;
    int cyc = 0;
    int n;
    logic [9:0] sec;
    logic [7:0] exp_mem [int];

    // Host wins the wire when driving
    assign dq_bus = pins.dq_oe ? pins.dq_out : dev_dq;

    sfpc_host #(.PWRUP_WAIT(PW), .POLL_LIMIT(50)) i_dut (
        .core_clk(core_clk), .rstn(rstn), .req(req), .req_ready(req_ready),
        .rsp(rsp), .lock_on(lock_on), .pins(pins), .pin_dq_in(dq_bus));
    sfpc_flash_model #(.MFG_CODE(MFG), .DEV_CODE(DEV)) i_flash (
        .addr(pins.addr), .dq_bus(dq_bus), .ce_n(pins.ce_n), .oe_n(pins.oe_n),
        .we_n(pins.we_n), .slow(slow), .dev_dq(dev_dq), .dev_oe(dev_oe), .viol(viol));

    initial forever #25 core_clk = ~core_clk;

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check

    task automatic print_verdict();
        if (n_fail == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : print_verdict

    // Request held until taken, then wait for the response pulse
    task automatic do_op(input sfpc_op_e o, input logic [16:0] a, input logic [7:0] d);
        @(negedge core_clk);
        req = '{valid: 1'b1, op: o, addr: a, data: d};
        @(posedge core_clk);
        while (req_ready !== 1'b1)
            @(posedge core_clk);
        @(negedge core_clk);
        req.valid = 1'b0;
        while (rsp.valid !== 1'b1)
            @(negedge core_clk);
        r = rsp;
    endtask : do_op

    function automatic logic [7:0] exp_rd(input logic [16:0] a);
        return exp_mem.exists(a) ? exp_mem[a] : 8'hFF;
    endfunction : exp_rd

    task automatic rd_chk(input logic [16:0] a);
        do_op(OP_READ, a, 8'h00);
        check("read_data", r.data, exp_rd(a));
    endtask : rd_chk

    // Mode 0 stores, 1 is refused by the lock, 2 outlasts the poll limit
    task automatic prog(input logic [9:0] s, input logic lk, input int mode);
        logic [7:0] d [128];
        int ord [128];
        int j;
        int t;
        logic [7:0] old;
        old = exp_rd({s, 7'h7F});
        foreach (ord[i]) begin
            ord[i] = i;
            d[i] = 8'($urandom);
        end
        for (int i = 127; i > 0; i--) begin
            j = $urandom_range(i);
            t = ord[i];
            ord[i] = ord[j];
            ord[j] = t;
        end
        if (mode == 1)
            d[127][7] = old[7]; // Keeps the poll outcome predictable
        foreach (ord[k]) begin
            do_op(OP_LOAD, {s, 7'(ord[k])}, d[ord[k]]);
            check("load_echo", r.data, d[ord[k]]);
        end
        @(negedge core_clk);
        lock_on = lk;
        slow = (mode == 2);
        do_op(OP_PROG, {s, 7'h00}, 8'h00);
        check("prog_err", r.err, mode == 2);
        if (mode == 1)
            check("poll_end", r.data, old);
        if (mode == 0)
            check("poll_end", r.data, d[127]);
        if (mode != 1)
            foreach (d[i])
                exp_mem[{s, 7'(i)}] = d[i];
        if (mode == 2)
            repeat (2100) @(negedge core_clk);
        slow = 1'b0;
        rd_chk({s, 7'h00});
        rd_chk({s, 7'h7F});
        rd_chk({s, 7'($urandom)});
    endtask : prog

    // ----------------------------------------------------------------
    // Monitors and run
    // ----------------------------------------------------------------
    always @(negedge core_clk) begin
        if (rstn) begin
            check("bus_clash", pins.dq_oe & dev_oe, 1'b0);
            check("write_oe", !pins.we_n & !pins.oe_n, 1'b0);
        end
    end

    // Full run needs about 18000 cycles
    initial forever begin
        @(posedge core_clk);
        cyc++;
        if (cyc == 60000) begin
            n_fail++;
            $display("MISMATCH run_length expected %0d seen %0d", 59999, cyc);
            print_verdict();
        end
    end

    initial begin
        void'($urandom(34808));
        repeat (4) @(negedge core_clk);
        check("ready_in_reset", req_ready, 1'b0);
        check("idle_pins", {pins.ce_n, pins.oe_n, pins.we_n, pins.dq_oe}, 4'hE);
        rstn = 1'b1;
        n = 0;
        while (req_ready !== 1'b1 && n < 100) begin
            @(negedge core_clk);
            n++;
        end
        check("pwrup_wait", n >= PW && n <= PW + 2, 1'b1);
        repeat (4) rd_chk(17'($urandom));
        sec = 10'($urandom);
        prog(sec, 1'b0, 0);
        do_op(OP_ID, 17'h00000, 8'h00);
        check("id_maker", r.data, MFG);
        do_op(OP_ID, 17'h00001, 8'h00);
        check("id_device", r.data, DEV);
        rd_chk({sec, 7'h05});
        prog(sec + 10'h001, 1'b1, 0);
        prog(sec + 10'h002, 1'b0, 1);
        prog(sec + 10'h003, 1'b1, 2);
        check("host_faults", viol, 0);
        print_verdict();
    end
endmodule : sector_flash_program_ctrl_tb_top
